/* logic/counter_pwm_compare_regs.svh */
// constants for the 10-bit up/down counter with compare and pwm
// assumes a nibble-wide register port with a 3-bit register index
`ifndef COUNTER_PWM_COMPARE_REGS_SVH
`define COUNTER_PWM_COMPARE_REGS_SVH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define CPC_ADDR_CLK_DIR   3'h0
`define CPC_ADDR_RUN       3'h1
`define CPC_ADDR_SYS_ONE   3'h2
`define CPC_ADDR_DATA_LOW  3'h3
`define CPC_ADDR_DATA_MID  3'h4
`define CPC_ADDR_DATA_HIGH 3'h5
`define CPC_ADDR_PWM_ROUTE 3'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CPC_BIT_UP         3
`define CPC_BIT_START      3
`define CPC_BIT_EVENT      2
`define CPC_BIT_CMP_EN     1
`define CPC_BIT_LOAD       0
`define CPC_BIT_IRQ_EN     3
`define CPC_BIT_SLEEP      2
`define CPC_BIT_FULL_CMP   1
`define CPC_BIT_TEST       0
`define CPC_BIT_ROUTE      0

// ------------------------------------------------------------
// reset values and length masks
// ------------------------------------------------------------
`define CPC_RST_NIBBLE     4'h0
`define CPC_RST_COUNT      10'h000
`define CPC_MASK_10        10'h3ff
`define CPC_MASK_8         10'h0ff
`define CPC_MASK_6         10'h03f
`define CPC_MASK_4         10'h00f

`endif

/* logic/counter_pwm_compare_pkg.sv */
// types shared by the counter, its clock selector and the bench
// assumes the constants header is compiled alongside
`default_nettype none

package counter_pwm_compare_pkg;

  // register index as seen on the nibble port
  typedef enum logic [2:0] {
    REG_CLK_DIR   = 3'b000,
    REG_RUN       = 3'b001,
    REG_SYS_ONE   = 3'b010,
    REG_DATA_LOW  = 3'b011,
    REG_DATA_MID  = 3'b100,
    REG_DATA_HIGH = 3'b101,
    REG_PWM_ROUTE = 3'b110
  } reg_addr_t;

  // counter length selection
  typedef enum logic [1:0] {
    LEN_10 = 2'b00,
    LEN_8  = 2'b01,
    LEN_6  = 2'b10,
    LEN_4  = 2'b11
  } len_sel_t;

endpackage

`default_nettype wire

/* logic/count_clock_select.sv */
// clock source selector: synchronises the eight candidate clocks and
// reports rising and falling edges of the selected one as pulses
// assumes all sources are asynchronous and slower than half of clk
`timescale 1ns/100ps
`default_nettype none

module count_clock_select
  import counter_pwm_compare_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] srcSel,        // clock_source_select field
  input  wire logic       portABitZero,  // port A bit 0 after polarity
  input  wire logic       portABitThree, // port A bit 3 after polarity
  input  wire logic [5:0] prescTaps,     // taps 15,12,10,8,4,1 in bits 0..5
  output logic            riseTick,      // selected source rose
  output logic            fallTick       // selected source fell
);

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  logic       [7:0] rawSrc;    // code order: pa0, taps, pa3
  wire logic  [7:0] syncOut;   // second stage of every source
  logic             selLvl_r;  // selected level, one cycle old

  assign rawSrc = {portABitThree, prescTaps[5:0], portABitZero};

  // two flip-flops per source; every source is off our clock
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      logic stageA_r;  // first stage, read only by second stage
      logic stageB_r;  // second stage, the only one logic reads
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stageA_r <= 1'b0;
          stageB_r <= 1'b0;
        end else begin
          stageA_r <= rawSrc[gi];
          stageB_r <= stageA_r;
        end
      end
      // flops stay local so no vector is written from eight processes
      assign syncOut[gi] = stageB_r;
    end
  endgenerate

  // ------------------------------------------------------------
  // edge detection on the selected source
  // ------------------------------------------------------------
  // switching the source may fake one edge; software stops first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selLvl_r <= 1'b0;
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end else begin
      selLvl_r <= syncOut[srcSel];
      riseTick <= syncOut[srcSel] & ~selLvl_r;
      fallTick <= ~syncOut[srcSel] & selLvl_r;
    end
  end

endmodule

`default_nettype wire

/* logic/counter_pwm_compare.sv */
// 10-bit up/down counter with preset load, limited length, compare
// match and pwm generator, programmed through nibble registers
// assumes a single 250 MHz clock, register port without wait states,
// and that the port B direction and interrupt masks live elsewhere
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

`include "counter_pwm_compare_regs.svh"

// Behaviour
// - compare off forces pwm: up 0, down 1
// - up mode: rollover sets pwm, match clears
// - pwm match uses selected length bits only
// - irqs keep firing while pwm runs
// - down mode: start 1, rollover 0, match 1
// - load copies preset, self clears, reads 0
// - low nibble read latches upper shadow bits
// - rollover irq at zero or length maximum
// - loading never raises an irq
// - direction change inverts the counter value
// - loading zero stops counter, no irq
// - source code selects port or prescaler tap
// - reset gives port bit zero, down count
// - length select picks 10, 8, 6, 4 bits
// - full compare select resets to limited
// - data registers: write preset, read count
// - route enable puts pwm on port pin
// - every load clears compare enable
// - full compare with pwm route counts pulses then stops
// - cyclic step by one per rising source edge
module counter_pwm_compare
  import counter_pwm_compare_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] regAddr,       // register index
  input  wire logic [3:0] regWrData,     // write nibble
  input  wire logic       regWrStb,      // one-cycle write strobe
  input  wire logic       regRdStb,      // one-cycle read strobe
  output logic      [3:0] regRdData,     // read nibble, cycle after strobe
  input  wire logic       portABitZero,  // port A bit 0 clock input
  input  wire logic       portABitThree, // port A bit 3 clock input
  input  wire logic [5:0] prescTaps,     // prescaler taps 15,12,10,8,4,1
  output logic            pwmOutputPin,  // pwm level for port B bit 3
  output logic            pwmRouteOn,    // port B bit 3 takes pwm level
  output logic            rolloverIrq,   // one-cycle rollover request
  output logic            matchIrq       // one-cycle compare request
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic       upMode_r;      // 1 counts up, 0 counts down
  logic [2:0] srcSel_r;      // clock_source_select
  logic       start_r;       // run control
  logic       eventMode_r;   // event_tally_mode
  logic       compareEn_r;   // compare_enable
  logic       irqEnable_r;   // global_irq_enable, stored only
  logic       sleepBit_r;    // stored only
  logic       fullCmp_r;     // full_compare_irq_select
  logic       testBit_r;     // factory_test_bit, stored only
  logic       pwmRoute_r;    // pwm_route_enable
  logic [9:0] preset_r;      // preset_compare_value
  len_sel_t   lenSel_r;      // length_select
  logic [9:0] count_r;       // live counter
  logic [5:0] shadow_r;      // shadow_upper_bits
  logic       armed_r;       // start synchronisation seen
  logic       pwmState_r;    // internal pwm level

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  reg_addr_t  addrEnum;      // typed address
  logic       wrClkDir;      // write to clock/direction register
  logic       wrRun;         // write to run control
  logic       loadNow;       // load request this cycle
  logic       dirFlip;       // direction changes this cycle
  logic       rdLow;         // low nibble read

  assign addrEnum = reg_addr_t'(regAddr);
  assign wrClkDir = regWrStb && (regAddr == `CPC_ADDR_CLK_DIR);
  assign wrRun    = regWrStb && (regAddr == `CPC_ADDR_RUN);
  assign loadNow  = wrRun && regWrData[`CPC_BIT_LOAD];
  assign dirFlip  = wrClkDir && (regWrData[`CPC_BIT_UP] != upMode_r);
  assign rdLow    = regRdStb && (regAddr == `CPC_ADDR_DATA_LOW);

  // ------------------------------------------------------------
  // clock source
  // ------------------------------------------------------------
  logic riseTick;  // selected source rose
  logic fallTick;  // selected source fell

  // source code to clock mapping lives in the selector
  count_clock_select count_clock_select_inst (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .srcSel        (srcSel_r),
    .portABitZero  (portABitZero),
    .portABitThree (portABitThree),
    .prescTaps     (prescTaps),
    .riseTick      (riseTick),
    .fallTick      (fallTick)
  );

  // ------------------------------------------------------------
  // step arithmetic
  // ------------------------------------------------------------
  logic [9:0] lenMask;    // bits of the selected length
  logic       stepNow;    // counter advances this cycle
  logic [9:0] countNxt;   // value after one step
  logic       rollHit;    // new value is the rollover value
  logic       matchLim;   // match on selected length
  logic       matchFull;  // match on all ten bits
  logic       matchIrqEv; // compare request condition

  // length mask from the high data nibble
  always_comb begin
    case (lenSel_r)
      LEN_10:  lenMask = `CPC_MASK_10;
      LEN_8:   lenMask = `CPC_MASK_8;
      LEN_6:   lenMask = `CPC_MASK_6;
      LEN_4:   lenMask = `CPC_MASK_4;
      default: lenMask = `CPC_MASK_10;
    endcase
  end

  // normal mode waits for a falling edge first; event mode does not
  // a load or a direction change wins over a step in the same cycle
  assign stepNow  = start_r && riseTick && (armed_r || eventMode_r) &&
                    !loadNow && !dirFlip;
  // full width carry lets upper bits tally pulses
  assign countNxt = upMode_r ? count_r + 10'h001 : count_r - 10'h001;
  // rollover at length maximum up, zero down
  assign rollHit  = upMode_r ? ((countNxt & lenMask) == lenMask)
                             : ((countNxt & lenMask) == 10'h000);
  // pwm match ignores the full compare select
  assign matchLim = ((countNxt ^ preset_r) & lenMask) == 10'h000;
  assign matchFull = (countNxt == preset_r);
  // full select widens only the interrupt compare
  assign matchIrqEv = compareEn_r && (fullCmp_r ? matchFull : matchLim);

  // ------------------------------------------------------------
  // start synchronisation
  // ------------------------------------------------------------
  // a falling edge latched while running arms the first count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed_r <= 1'b0;
    end else if (!start_r) begin
      armed_r <= 1'b0;
    end else if (fallTick) begin
      armed_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // clock and direction register
  // ------------------------------------------------------------
  // reset selects port bit zero and down counting
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upMode_r <= 1'b0;
      srcSel_r <= 3'h0;
    end else if (wrClkDir) begin
      upMode_r <= regWrData[`CPC_BIT_UP];
      srcSel_r <= regWrData[2:0];
    end
  end

  // ------------------------------------------------------------
  // run control register
  // ------------------------------------------------------------
  // load clears compare enable zero load stops
  // a pwm run with full compare halts on its compare request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_r     <= 1'b0;
      eventMode_r <= 1'b0;
      compareEn_r <= 1'b0;
    end else if (wrRun) begin
      eventMode_r <= regWrData[`CPC_BIT_EVENT];
      if (loadNow) begin
        compareEn_r <= 1'b0;
        start_r     <= (preset_r != 10'h000) && regWrData[`CPC_BIT_START];
      end else begin
        compareEn_r <= regWrData[`CPC_BIT_CMP_EN];
        start_r     <= regWrData[`CPC_BIT_START];
      end
    end else if (stepNow && matchIrqEv && fullCmp_r && pwmRoute_r) begin
      start_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // system control and routing registers
  // ------------------------------------------------------------
  // full compare select resets to limited compare
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEnable_r <= 1'b0;
      sleepBit_r  <= 1'b0;
      fullCmp_r   <= 1'b0;
      testBit_r   <= 1'b0;
      pwmRoute_r  <= 1'b0;
    end else if (regWrStb) begin
      if (regAddr == `CPC_ADDR_SYS_ONE) begin
        irqEnable_r <= regWrData[`CPC_BIT_IRQ_EN];
        sleepBit_r  <= regWrData[`CPC_BIT_SLEEP];
        fullCmp_r   <= regWrData[`CPC_BIT_FULL_CMP];
        testBit_r   <= regWrData[`CPC_BIT_TEST];
      end
      if (regAddr == `CPC_ADDR_PWM_ROUTE) begin
        pwmRoute_r <= regWrData[`CPC_BIT_ROUTE];
      end
    end
  end

  // ------------------------------------------------------------
  // preset, compare and length nibbles
  // ------------------------------------------------------------
  // writes land in the preset, never in the live count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preset_r <= `CPC_RST_COUNT;
      lenSel_r <= LEN_10;
    end else if (regWrStb) begin
      case (addrEnum)
        REG_DATA_LOW:  preset_r[3:0] <= regWrData;
        REG_DATA_MID:  preset_r[7:4] <= regWrData;
        REG_DATA_HIGH: begin
          preset_r[9:8] <= regWrData[1:0];
          lenSel_r      <= len_sel_t'(regWrData[3:2]);
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // load first, then direction inversion, then stepping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= `CPC_RST_COUNT;
    end else if (loadNow) begin
      count_r <= preset_r;
    end else if (dirFlip) begin
      count_r <= ~count_r;
    end else if (stepNow) begin
      count_r <= countNxt;
    end
  end

  // ------------------------------------------------------------
  // interrupt requests
  // ------------------------------------------------------------
  // only a step raises them; a load never does
  // no gating by the pwm route, masks sit outside
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rolloverIrq <= 1'b0;
      matchIrq    <= 1'b0;
    end else begin
      rolloverIrq <= stepNow && rollHit;
      matchIrq    <= stepNow && matchIrqEv;
    end
  end

  // ------------------------------------------------------------
  // pwm generator
  // ------------------------------------------------------------
  // a match on the rollover step wins, so the pulse ends cleanly
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwmState_r <= 1'b1;
    end else if (!compareEn_r) begin
      pwmState_r <= !upMode_r;
    end else if (stepNow && matchLim) begin
      pwmState_r <= !upMode_r;
    end else if (stepNow && rollHit) begin
      pwmState_r <= upMode_r;
    end
  end

  // pin level and route flag, both from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwmOutputPin <= 1'b0;
      pwmRouteOn   <= 1'b0;
    end else begin
      pwmOutputPin <= pwmRoute_r & pwmState_r;
      pwmRouteOn   <= pwmRoute_r;
    end
  end

  // ------------------------------------------------------------
  // read path and shadow latch
  // ------------------------------------------------------------
  // upper bits frozen by the low read keep a three-read consistent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_r <= 6'h00;
    end else if (rdLow) begin
      shadow_r <= count_r[9:4];
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst || !regRdStb) begin
      regRdData <= `CPC_RST_NIBBLE;
    end else begin
      case (addrEnum)
        REG_CLK_DIR:   regRdData <= {upMode_r, srcSel_r};
        REG_RUN:       regRdData <= {start_r, eventMode_r, compareEn_r, 1'b0};
        REG_SYS_ONE:   regRdData <= {irqEnable_r, sleepBit_r, fullCmp_r, testBit_r};
        REG_DATA_LOW:  regRdData <= count_r[3:0];
        REG_DATA_MID:  regRdData <= shadow_r[3:0];
        REG_DATA_HIGH: regRdData <= {lenSel_r, shadow_r[5:4]};
        REG_PWM_ROUTE: regRdData <= {3'h0, pwmRoute_r};
        default:       regRdData <= `CPC_RST_NIBBLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence seqLoad;
    wrRun && regWrData[`CPC_BIT_LOAD];
  endsequence

  sequence seqUpRoll;
    stepNow && upMode_r && compareEn_r && rollHit && !matchLim;
  endsequence

  sequence seqDownMatch;
    stepNow && !upMode_r && compareEn_r && matchLim;
  endsequence

  AST_PWM_IDLE_LEVEL: assert property (
    @(posedge clk) disable iff (sys_rst)
    !compareEn_r |=> (pwmState_r == !$past(upMode_r)))
    else $error("pwm idle level wrong");

  AST_UP_ROLL_HIGH: assert property (
    @(posedge clk) disable iff (sys_rst)
    seqUpRoll |=> pwmState_r ##1 pwmOutputPin == $past(pwmRoute_r))
    else $error("up rollover did not raise pwm");

  AST_DOWN_MATCH_HIGH: assert property (
    @(posedge clk) disable iff (sys_rst)
    seqDownMatch |=> pwmState_r)
    else $error("down match did not raise pwm");

  AST_LOAD_COPIES: assert property (
    @(posedge clk) disable iff (sys_rst)
    seqLoad |=> (count_r == $past(preset_r)) && !compareEn_r)
    else $error("load did not copy preset or clear compare");

  AST_LOAD_NO_IRQ: assert property (
    @(posedge clk) disable iff (sys_rst)
    seqLoad |=> !rolloverIrq && !matchIrq)
    else $error("load raised an interrupt");

  AST_ZERO_LOAD_STOPS: assert property (
    @(posedge clk) disable iff (sys_rst)
    seqLoad and (preset_r == 10'h000) |=> !start_r && !rolloverIrq && !matchIrq)
    else $error("zero load did not stop");

  AST_DIR_INVERTS: assert property (
    @(posedge clk) disable iff (sys_rst)
    dirFlip && !loadNow |=> count_r == ~$past(count_r))
    else $error("direction change did not invert");

  AST_SHADOW_READ: assert property (
    @(posedge clk) disable iff (sys_rst)
    rdLow |=> (shadow_r == $past(count_r[9:4])) &&
              (regRdData == $past(count_r[3:0])))
    else $error("low read did not latch shadow");

  AST_LOAD_READS_ZERO: assert property (
    @(posedge clk) disable iff (sys_rst)
    regRdStb && (regAddr == `CPC_ADDR_RUN) |=> !regRdData[`CPC_BIT_LOAD])
    else $error("load bit read back as one");

  AST_ROLL_IRQ: assert property (
    @(posedge clk) disable iff (sys_rst)
    stepNow && rollHit |=> rolloverIrq ##1 !rolloverIrq || stepNow)
    else $error("rollover request missing");

endmodule

`default_nettype wire

/* dv/test_counter_pwm_compare.sv */
// self-checking bench for the nibble-programmed counter with pwm
// assumes the design drives irqs as one-cycle pulses, sources held 6 clk
`timescale 1ns/100ps
`default_nettype none

module test_counter_pwm_compare;
  import counter_pwm_compare_pkg::*;
  logic       clk       = 1'h0;
  logic       sysRst    = 1'h1;
  logic       regWrStb  = 1'h0;
  logic       regRdStb  = 1'h0;
  logic [2:0] regAddr   = 3'h0;
  logic [3:0] regWrData = 4'h0;
  logic [7:0] srcV      = 8'h00; // eight sources, bit index is the select code
  logic [3:0] regRdData;
  logic       pwmOutputPin, pwmRouteOn, rolloverIrq, matchIrq;
  int num_errors = 0, num_checks = 0, seed = 66859;
  // reference model state, kept as plain integers
  int cnt = 0, preset_compare_value = 0, up = 0, src = 0, ev = 0, cmpEn = 0, start = 0;
  int armed = 0, full = 0, sys = 0, len = 0, route = 0, pwm = 1, sh = 0;
  int expRoll = 0, expMatch = 0, gotRoll = 0, gotMatch = 0;

  always #2 clk = ~clk;

  counter_pwm_compare counter_pwm_compare_inst (
    .clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .portABitZero(srcV[0]), .portABitThree(srcV[7]), .prescTaps(srcV[6:1]),
    .pwmOutputPin(pwmOutputPin), .pwmRouteOn(pwmRouteOn),
    .rolloverIrq(rolloverIrq), .matchIrq(matchIrq));

  // ----------------------------------------------------------
  // irq pulse tally, compared against the model after each step
  // ----------------------------------------------------------
  always @(posedge clk) begin
    if (rolloverIrq === 1'h1) gotRoll++;
    if (matchIrq === 1'h1) gotMatch++;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // register port; one idle cycle between accesses avoids a double drive
  // ----------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    @(posedge clk) begin
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'h1;
    end
    @(posedge clk) regWrStb <= 1'h0;
    case (a)
      3'h0: begin
        if (d[3] != up) cnt = cnt ^ 'h3ff;
        up = d[3];
        src = d[2:0];
      end
      3'h1: begin
        ev = d[2];
        cmpEn = d[1];
        start = d[3];
        armed = 0;
        if (d[0]) begin
          cnt = preset_compare_value;
          cmpEn = 0;
          if (preset_compare_value == 0) start = 0;
        end
      end
      3'h2: begin
        sys = d;
        full = d[1];
      end
      3'h3: preset_compare_value = (preset_compare_value & 'h3f0) | d;
      3'h4: preset_compare_value = (preset_compare_value & 'h30f) | (d << 4);
      3'h5: begin
        preset_compare_value = (preset_compare_value & 'h0ff) | (d[1:0] << 8);
        len = d[3:2];
      end
      3'h6: route = d[0];
      default: ;
    endcase
    if (!cmpEn) pwm = !up;
  endtask

  task automatic rd(input logic [2:0] a);
    logic [3:0] e;
    case (a)
      3'h0: e = {up[0], src[2:0]};
      3'h1: e = {start[0], ev[0], cmpEn[0], 1'h0};
      3'h2: e = sys[3:0];
      3'h3: e = cnt[3:0];
      3'h4: e = sh[3:0];
      3'h5: e = {len[1:0], sh[5:4]};
      3'h6: e = {3'h0, route[0]};
      default: e = 4'h0;
    endcase
    if (a == 3'h3) sh = cnt >> 4;
    @(posedge clk) begin
      regAddr <= a;
      regRdStb <= 1'h1;
    end
    @(posedge clk) regRdStb <= 1'h0;
    #1 check(10'(regRdData), 10'(e));
    @(posedge clk) #1 check(10'(regRdData), 10'h000);
  endtask

  // preset or compare as three nibbles, length in the high nibble
  task automatic wrData(input int v, input int l);
    wr(3'h3, 4'(v));
    wr(3'h4, 4'(v >> 4));
    wr(3'h5, {2'(l), 2'(v >> 8)});
  endtask

  // one counting step of the model on a source rise
  task automatic mstep();
    int msk, lm, roll;
    msk = 'h3ff >> (2 * len);
    cnt = (up ? cnt + 1 : cnt - 1) & 'h3ff;
    lm = cmpEn && (cnt & msk) == (preset_compare_value & msk);
    roll = (cnt & msk) == (up ? msk : 0);
    expRoll += roll;
    if (cmpEn) pwm = lm ? !up : (roll ? up : pwm);
    if (cmpEn && (full ? cnt == preset_compare_value : lm)) begin
      expMatch++;
      if (full && route) start = 0;
    end
  endtask

  // source pulses: selected bit high 6 clk, unselected bits random noise
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) srcV <= 8'($random(seed)) | (8'h01 << src);
      if (start && (ev || armed)) mstep();
      repeat (6) @(posedge clk);
      srcV <= 8'h00;
      if (start) armed = 1;
      repeat (6) @(posedge clk);
      #1 check(10'(gotRoll), 10'(expRoll));
      check(10'(gotMatch), 10'(expMatch));
      check(10'(pwmOutputPin), 10'(route & (cmpEn ? pwm : !up)));
      check(10'(pwmRouteOn), 10'(route));
    end
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sysRst <= 1'h0;
    for (int a = 0; a < 8; a++) rd(3'(a));
    wrData('h010, 0);
    wr(3'h1, 4'hd); // load with start in event mode
    rd(3'h1);
    rd(3'h3);
    pulse(1);
    rd(3'h4);
    rd(3'h5);
    rd(3'h3);
    pulse(17);
    wrData(0, 0);
    wr(3'h1, 4'h9);
    rd(3'h1);
    pulse(2);
    wr(3'h0, 4'h9);
    rd(3'h3);
    rd(3'h4);
    rd(3'h5);
    wrData(0, 3);
    wr(3'h1, 4'h1);
    wr(3'h6, 4'h1);
    rd(3'h6);
    wrData(($random(seed) & 'h3ff) | 1, 3);
    wr(3'h1, 4'ha); // normal mode start with compare
    for (int c = 1; c < 8; c++) begin
      wr(3'h0, 4'(8 + c));
      wrData(($random(seed) & 'h3ff) | 1, c & 3);
      pulse(6);
    end
    wrData(0, 3);
    wr(3'h1, 4'h5);
    wr(3'h2, 4'($random(seed)) | 4'h2);
    rd(3'h2);
    wrData('h052, 3);
    wr(3'h1, 4'he);
    pulse(100);
    rd(3'h1);
    wr(3'h2, 4'h0);
    wr(3'h0, 4'h0);
    wrData('h005, 3);
    wr(3'h1, 4'h5);
    pulse(1);
    wrData('h3a2, 3);
    wr(3'h1, 4'he);
    pulse(40);
    end_of_test();
  end

  // hang guard, well beyond the few thousand cycles the sequence needs
  initial begin
    #60000;
    num_errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
